// File: include/ptw_regs.vh
// Constants for the paging translation unit: register offsets, control
// bits, table entry flags and linear address fields.
// Assumes a 5-bit byte address on the register port, one word per register.
`ifndef PTW_REGS_VH
`define PTW_REGS_VH

// Register offsets
`define PTW_OFS_MAIN 5'h00
`define PTW_OFS_FEAT 5'h04
`define PTW_OFS_ROOT 5'h08
`define PTW_OFS_INV1 5'h0C
`define PTW_OFS_INVALL 5'h10
`define PTW_OFS_STAT 5'h14
`define PTW_OFS_FLIN 5'h18

// Control and status bits
`define PTW_MAIN_ON 0
`define PTW_FEAT_LPE 0
`define PTW_FEAT_WIDE 1
`define PTW_FEAT_KEEP 2
`define PTW_ST_BUSY 0
`define PTW_ST_FAULT 1
`define PTW_PRIV_TOP 2'h0

// Table entry flags
`define PTW_E_P 0
`define PTW_E_A 5
`define PTW_E_D 6
`define PTW_E_PS 7
`define PTW_E_G 8
`define PTW_E_BASE 35:12
`define PTW_E_LO 31:0

// Walk levels
`define PTW_LVL_PDPT 2'h0
`define PTW_LVL_PDE 2'h1
`define PTW_LVL_PTE 2'h2

// Linear address fields
`define PTW_LA_PDPT 31:30
`define PTW_LA_PDE_W 29:21
`define PTW_LA_PTE_W 20:12
`define PTW_LA_PDE_N 31:22
`define PTW_LA_PTE_N 21:12
`define PTW_LA_VPN 31:12
`define PTW_LA_OFS4K 11:0
`define PTW_LA_OFS2M 20:0
`define PTW_LA_OFS4M 21:0
`define PTW_TAG_2M 19:9
`define PTW_TAG_4M 19:10
`define PTW_LA_HI2M 31:21
`define PTW_PPN_2M 23:9
`define PTW_PPN_4M 23:10
`define PTW_ROOT_PDPT 31:5
`define PTW_ROOT_PD 31:12

// Address padding and reset values
`define PTW_HI_ZERO 4'h0
`define PTW_PAD_W 3'h0
`define PTW_PAD_N 2'h0
`define PTW_W32_ZERO 32'h0000_0000

`endif

// File: logic/ptw_walker.v
// Paging translation unit: translation buffers, table walker, control regs.
// Assumes a core on the same clock issuing one request at a time while
// busy_q is low, and a memory that answers each access with mem_ack.
`timescale 1ns/100ps
`include "ptw_regs.vh"
`default_nettype none

module ptw_walker #(
   parameter TLB_N = 4,
   parameter LOG2N = 2
) (
   input wire clk,
   input wire rst,
   input wire [4:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_q,
   input wire [1:0] cur_priv,
   input wire req_valid,
   input wire [31:0] req_lin,
   input wire req_write,
   input wire req_fetch,
   output reg busy_q,
   output reg rsp_valid_q,
   output reg [35:0] rsp_phys_q,
   output reg rsp_fault_q,
   output reg mem_rd_q,
   output reg mem_wr_q,
   output reg mem_lock_q,
   output reg mem_dword_q,
   output reg [35:0] mem_addr_q,
   output reg [63:0] mem_wdata_q,
   input wire [63:0] mem_rdata,
   input wire mem_ack
);

   localparam NTOT = 4 * TLB_N;
   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_RD = 4'b0010;
   localparam [3:0] S_CHK = 4'b0100;
   localparam [3:0] S_WR = 4'b1000;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function tag_hit;
      input lg;
      input wd;
      input [19:0] tag;
      input [31:0] lin;
      begin
         if (!lg)
            tag_hit = (tag == lin[`PTW_LA_VPN]);
         else if (wd)
            tag_hit = (tag[`PTW_TAG_2M] == lin[`PTW_LA_HI2M]);
         else
            tag_hit = (tag[`PTW_TAG_4M] == lin[`PTW_LA_PDE_N]);
      end
   endfunction

   function [35:0] phys_of;
      input lg;
      input wd;
      input [23:0] ppn;
      input [31:0] lin;
      begin
         if (!lg)
            phys_of = {ppn, lin[`PTW_LA_OFS4K]};
         else if (wd)
            phys_of = {ppn[`PTW_PPN_2M], lin[`PTW_LA_OFS2M]};
         else
            phys_of = {ppn[`PTW_PPN_4M], lin[`PTW_LA_OFS4M]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   reg trans_on_q, lpe_q, wide_q, keep_q, fault_q;
   reg [31:0] root_q, flin_q;
   reg [3:0] state_q;
   reg [1:0] lvl_q;
   reg [31:0] lin_q;
   reg wr_q, fetch_q, re_use_q;
   reg [LOG2N+1:0] re_k_q;
   reg [63:0] ent_q;

   wire priv_ok = (cur_priv == `PTW_PRIV_TOP);
   wire fl_root = reg_wr & priv_ok & (reg_addr == `PTW_OFS_ROOT);
   wire fl_all = reg_wr & priv_ok & (reg_addr == `PTW_OFS_INVALL);
   wire fl_one = reg_wr & priv_ok & (reg_addr == `PTW_OFS_INV1);
   wire fl_glob = fl_root | fl_all;

   ////////////////////////////////////////////////////////////////////////
   // Translation buffers: index = {fetch, large, slot}

   reg [NTOT-1:0] t_v, t_g, t_d;
   reg [19:0] t_tag [0:NTOT-1];
   reg [23:0] t_ppn [0:NTOT-1];
   reg [LOG2N-1:0] rr_q [0:3];

   reg hit;
   reg [LOG2N+1:0] hit_k;
   integer k;
   integer j;

   always @* begin
      hit = 1'b0;
      hit_k = {(LOG2N+2){1'b0}};
      for (k = 0; k < NTOT; k = k + 1) begin
         if (t_v[k] && (((k / TLB_N) >= 2) == req_fetch)
             && tag_hit(((k / TLB_N) % 2) == 1, wide_q, t_tag[k], req_lin)) begin
            hit = 1'b1;
            hit_k = k[LOG2N+1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Walk decode

   wire lvl_pdpt = (lvl_q == `PTW_LVL_PDPT);
   wire lvl_pde = (lvl_q == `PTW_LVL_PDE);
   wire lvl_pte = (lvl_q == `PTW_LVL_PTE);
   wire e_p = ent_q[`PTW_E_P];
   wire e_lg = lvl_pde & lpe_q & ent_q[`PTW_E_PS];
   wire res_bad = lpe_q & wide_q & ((lvl_pte & ent_q[`PTW_E_PS])
                  | (lvl_pde & !e_lg & ent_q[`PTW_E_D]));
   wire fin = lvl_pte | e_lg;
   wire need_a = !lvl_pdpt & !ent_q[`PTW_E_A];
   wire need_d = fin & wr_q & !ent_q[`PTW_E_D];
   wire upd = need_a | need_d;
   reg [63:0] ent_new;
   reg [35:0] nxt_addr;
   reg [35:0] start_addr;

   always @* begin
      ent_new = ent_q;
      if (need_a)
         ent_new[`PTW_E_A] = 1'b1;
      if (need_d)
         ent_new[`PTW_E_D] = 1'b1;
      if (lvl_pdpt)
         nxt_addr = {ent_q[`PTW_E_BASE], lin_q[`PTW_LA_PDE_W], `PTW_PAD_W};
      else if (wide_q)
         nxt_addr = {ent_q[`PTW_E_BASE], lin_q[`PTW_LA_PTE_W], `PTW_PAD_W};
      else
         nxt_addr = {ent_q[`PTW_E_BASE], lin_q[`PTW_LA_PTE_N], `PTW_PAD_N};
      if (wide_q)
         start_addr = {`PTW_HI_ZERO, root_q[`PTW_ROOT_PDPT],
                       req_lin[`PTW_LA_PDPT], `PTW_PAD_W};
      else
         start_addr = {`PTW_HI_ZERO, root_q[`PTW_ROOT_PD],
                       req_lin[`PTW_LA_PDE_N], `PTW_PAD_N};
   end

   wire chk_st = (state_q == S_CHK);
   wire wr_st = (state_q == S_WR);
   wire walk_bad = chk_st & (!e_p | res_bad);
   wire do_fill = fin & ((chk_st & !walk_bad & !upd) | (wr_st & mem_ack));
   wire [LOG2N+1:0] new_k = {fetch_q, e_lg, rr_q[{fetch_q, e_lg}]};
   wire reuse = re_use_q & (re_k_q[LOG2N] == e_lg);
   wire [LOG2N+1:0] fill_k = reuse ? re_k_q : new_k;

   ////////////////////////////////////////////////////////////////////////
   // Buffer storage

   always @(posedge clk) begin
      if (do_fill) begin
         t_tag[fill_k] <= lin_q[`PTW_LA_VPN];
         t_ppn[fill_k] <= ent_new[`PTW_E_BASE];
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         t_v <= {NTOT{1'b0}};
         t_g <= {NTOT{1'b0}};
         t_d <= {NTOT{1'b0}};
         for (j = 0; j < 4; j = j + 1)
            rr_q[j] <= {LOG2N{1'b0}};
      end else begin
         if (do_fill) begin
            t_v[fill_k] <= 1'b1;
            t_g[fill_k] <= ent_new[`PTW_E_G];
            t_d[fill_k] <= ent_new[`PTW_E_D];
            if (!reuse)
               rr_q[{fetch_q, e_lg}] <= rr_q[{fetch_q, e_lg}] + 1'b1;
         end
         for (j = 0; j < NTOT; j = j + 1) begin
            if (fl_glob && !(t_g[j] && keep_q))
               t_v[j] <= 1'b0;
            if (fl_one && tag_hit(((j / TLB_N) % 2) == 1, wide_q, t_tag[j], reg_wdata))
               t_v[j] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         trans_on_q <= 1'b0;
         lpe_q <= 1'b0;
         wide_q <= 1'b0;
         keep_q <= 1'b0;
         root_q <= `PTW_W32_ZERO;
         reg_rdata_q <= `PTW_W32_ZERO;
      end else begin
         if (reg_wr && reg_addr == `PTW_OFS_MAIN)
            trans_on_q <= reg_wdata[`PTW_MAIN_ON];
         if (reg_wr && reg_addr == `PTW_OFS_FEAT) begin
            lpe_q <= reg_wdata[`PTW_FEAT_LPE];
            wide_q <= reg_wdata[`PTW_FEAT_WIDE];
            keep_q <= reg_wdata[`PTW_FEAT_KEEP];
         end
         if (fl_root)
            root_q <= reg_wdata;
         reg_rdata_q <= `PTW_W32_ZERO;
         if (reg_rd) begin
            case (reg_addr)
               `PTW_OFS_MAIN: reg_rdata_q[`PTW_MAIN_ON] <= trans_on_q;
               `PTW_OFS_FEAT: begin
                  reg_rdata_q[`PTW_FEAT_LPE] <= lpe_q;
                  reg_rdata_q[`PTW_FEAT_WIDE] <= wide_q;
                  reg_rdata_q[`PTW_FEAT_KEEP] <= keep_q;
               end
               `PTW_OFS_ROOT: reg_rdata_q <= root_q;
               `PTW_OFS_STAT: begin
                  reg_rdata_q[`PTW_ST_BUSY] <= busy_q;
                  reg_rdata_q[`PTW_ST_FAULT] <= fault_q;
               end
               `PTW_OFS_FLIN: reg_rdata_q <= flin_q;
               default: reg_rdata_q <= `PTW_W32_ZERO;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request handling and table walk

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         busy_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_phys_q <= 36'h0_0000_0000;
         rsp_fault_q <= 1'b0;
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_lock_q <= 1'b0;
         mem_dword_q <= 1'b0;
         mem_addr_q <= 36'h0_0000_0000;
         mem_wdata_q <= 64'h0000_0000_0000_0000;
         lvl_q <= `PTW_LVL_PDPT;
         lin_q <= `PTW_W32_ZERO;
         wr_q <= 1'b0;
         fetch_q <= 1'b0;
         re_use_q <= 1'b0;
         re_k_q <= {(LOG2N+2){1'b0}};
         ent_q <= 64'h0000_0000_0000_0000;
         fault_q <= 1'b0;
         flin_q <= `PTW_W32_ZERO;
      end else begin
         rsp_valid_q <= 1'b0;
         if (reg_wr && reg_addr == `PTW_OFS_STAT && reg_wdata[`PTW_ST_FAULT])
            fault_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (req_valid) begin
                  lin_q <= req_lin;
                  wr_q <= req_write;
                  fetch_q <= req_fetch;
                  if (!trans_on_q) begin
                     rsp_valid_q <= 1'b1;
                     rsp_fault_q <= 1'b0;
                     rsp_phys_q <= {`PTW_HI_ZERO, req_lin};
                  end else if (hit && (!req_write || t_d[hit_k])) begin
                     rsp_valid_q <= 1'b1;
                     rsp_fault_q <= 1'b0;
                     rsp_phys_q <= phys_of(hit_k[LOG2N], wide_q, t_ppn[hit_k], req_lin);
                  end else begin
                     busy_q <= 1'b1;
                     re_use_q <= hit;
                     re_k_q <= hit_k;
                     mem_rd_q <= 1'b1;
                     mem_lock_q <= 1'b1;
                     mem_dword_q <= wide_q;
                     mem_addr_q <= start_addr;
                     lvl_q <= wide_q ? `PTW_LVL_PDPT : `PTW_LVL_PDE;
                     state_q <= S_RD;
                  end
               end
            end
            S_RD: begin
               if (mem_ack) begin
                  mem_rd_q <= 1'b0;
                  ent_q <= wide_q ? mem_rdata : {`PTW_W32_ZERO, mem_rdata[`PTW_E_LO]};
                  state_q <= S_CHK;
               end
            end
            S_CHK: begin
               if (walk_bad) begin
                  rsp_valid_q <= 1'b1;
                  rsp_fault_q <= 1'b1;
                  fault_q <= 1'b1;
                  flin_q <= lin_q;
                  busy_q <= 1'b0;
                  mem_lock_q <= 1'b0;
                  state_q <= S_IDLE;
               end else if (upd) begin
                  ent_q <= ent_new;
                  mem_wdata_q <= ent_new;
                  mem_wr_q <= 1'b1;
                  state_q <= S_WR;
               end else if (fin) begin
                  rsp_valid_q <= 1'b1;
                  rsp_fault_q <= 1'b0;
                  rsp_phys_q <= phys_of(e_lg, wide_q, ent_new[`PTW_E_BASE], lin_q);
                  busy_q <= 1'b0;
                  mem_lock_q <= 1'b0;
                  state_q <= S_IDLE;
               end else begin
                  mem_rd_q <= 1'b1;
                  mem_addr_q <= nxt_addr;
                  lvl_q <= lvl_q + 2'h1;
                  state_q <= S_RD;
               end
            end
            S_WR: begin
               if (mem_ack) begin
                  mem_wr_q <= 1'b0;
                  if (fin) begin
                     rsp_valid_q <= 1'b1;
                     rsp_fault_q <= 1'b0;
                     rsp_phys_q <= phys_of(e_lg, wide_q, ent_q[`PTW_E_BASE], lin_q);
                     busy_q <= 1'b0;
                     mem_lock_q <= 1'b0;
                     state_q <= S_IDLE;
                  end else begin
                     mem_rd_q <= 1'b1;
                     mem_addr_q <= nxt_addr;
                     lvl_q <= `PTW_LVL_PTE;
                     state_q <= S_RD;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

endmodule // ptw_walker

`default_nettype wire

// File: tb/ptw_mem_model.sv
// Memory holding the translation tables, raising ack lat+1 cycles after an access starts.
// Assumes one access at a time, held until ack.
`timescale 1ns/100ps
`default_nettype none
module ptw_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic rd,
   input wire logic wr,
   input wire logic [35:0] addr,
   input wire logic [63:0] wdata,
   output logic [63:0] rdata,
   output logic ack
);
   logic [63:0] mem [logic [35:0]];
   int lat = 0;
   int cnt;
   int n_rd = 0;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ack <= 1'h0;
         cnt <= 0;
         rdata <= 64'h0;
      end else begin
         rdata <= ~rdata;
         ack <= 1'h0;
         cnt <= 0;
         if ((rd || wr) && !ack && cnt < lat) begin
            cnt <= cnt + 1;
         end else if ((rd || wr) && !ack) begin
            ack <= 1'h1;
            if (wr) mem[addr] = wdata;
            if (rd) n_rd <= n_rd + 1;
            if (rd) rdata <= mem.exists(addr) ? mem[addr] : 64'h0;
         end
      end
   end
endmodule // ptw_mem_model
`default_nettype wire

// File: tb/ptw_tb.sv
// Self-checking bench for the paging translation unit.
// Assumes the memory model holds the tables the scenarios load.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam logic Y = 1'h1;
   localparam logic N = 1'h0;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [4:0] reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0, req_lin = 32'h0, reg_rdata_q;
   logic reg_wr = 1'h0, reg_rd = 1'h0, req_valid = 1'h0, req_write = 1'h0, req_fetch = 1'h0;
   logic [1:0] cur_priv = 2'h0;
   logic busy_q, rsp_valid_q, rsp_fault_q, mem_rd_q, mem_wr_q, mem_lock_q, mem_dword_q, mem_ack;
   logic [35:0] rsp_phys_q, mem_addr_q;
   logic [63:0] mem_wdata_q, mem_rdata;
   int error_cnt = 0;
   int cmp_count = 0;
   always #10 clk = ~clk;
   ptw_walker dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .cur_priv(cur_priv),
      .req_valid(req_valid), .req_lin(req_lin), .req_write(req_write), .req_fetch(req_fetch),
      .busy_q(busy_q), .rsp_valid_q(rsp_valid_q), .rsp_phys_q(rsp_phys_q),
      .rsp_fault_q(rsp_fault_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q),
      .mem_lock_q(mem_lock_q), .mem_dword_q(mem_dword_q), .mem_addr_q(mem_addr_q),
      .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   ptw_mem_model mem_u (.clk(clk), .rst(rst), .rd(mem_rd_q), .wr(mem_wr_q), .addr(mem_addr_q),
      .wdata(mem_wdata_q), .rdata(mem_rdata), .ack(mem_ack));
   //////////////////////////////
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic rw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] p);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      cur_priv <= p;
      @(posedge clk);
      reg_wr <= 1'h0;
      cur_priv <= 2'h0;
   endtask
   task automatic rr(input logic [4:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      chk("reg", {32'h0, e}, {32'h0, reg_rdata_q});
   endtask
   task automatic xl(input logic [31:0] la, input logic w, f, ef, mw, input logic [35:0] ep);
      int i;
      int n;
      i = 0;
      n = mem_u.n_rd;
      @(posedge clk);
      req_valid <= 1'h1;
      req_lin <= la;
      req_write <= w;
      req_fetch <= f;
      do begin
         @(posedge clk);
         req_valid <= 1'h0;
         #1;
         i++;
      end while (rsp_valid_q !== 1'h1 && i < 300);
      if (rsp_valid_q !== 1'h1) begin
         error_cnt++;
         $display("ERROR rsp_valid expected 1 seen %b", rsp_valid_q);
         final_report;
      end else begin
         chk("fault", {63'h0, ef}, {63'h0, rsp_fault_q});
         chk("walk", {63'h0, mw}, {63'h0, mem_u.n_rd != n});
         if (!ef) chk("phys", {28'h0, ep}, {28'h0, rsp_phys_q});
      end
   endtask
   task automatic t_small;
      rr(5'h00, 32'h0);
      rr(5'h1C, 32'h0);
      xl(32'h1234_5678, N, N, N, N, 36'h0_1234_5678);
      mem_u.mem[36'h1_0004] = 64'h2_0001;
      mem_u.mem[36'h2_000C] = 64'h5_0E01;
      rw(5'h00, 32'h1, 2'h0);
      rw(5'h08, 32'h1_0000, 2'h0);
      xl(32'h0040_3123, Y, N, N, Y, 36'h5_0123);
      chk("pte", 64'h5_0E61, mem_u.mem[36'h2_000C] & 64'hFFFF_FFFF);
      chk("pde", 64'h2_0021, mem_u.mem[36'h1_0004] & 64'hFFFF_FFFF);
      xl(32'h0040_3FFF, Y, N, N, N, 36'h5_0FFF);
      xl(32'h0040_3000, N, Y, N, Y, 36'h5_0000);
      rw(5'h08, 32'h1_0000, 2'h3);
      xl(32'h0040_3000, N, N, N, N, 36'h5_0000);
      rw(5'h08, 32'h1_0000, 2'h0);
      xl(32'h0040_3000, N, N, N, Y, 36'h5_0000);
      $display("t_small done");
   endtask
   task automatic t_large;
      mem_u.mem[36'h1_0008] = 64'h0C00_0081;
      mem_u.mem[36'h1_0010] = 64'hFFFF_FFFE;
      rw(5'h04, 32'h1, 2'h0);
      xl(32'h0080_1234, N, N, N, Y, 36'h0C00_1234);
      xl(32'h00C0_0000, N, N, Y, Y, 36'h0);
      xl(32'h0100_0000, N, N, Y, Y, 36'h0);
      rr(5'h14, 32'h2);
      rr(5'h18, 32'h0100_0000);
      rw(5'h14, 32'h2, 2'h0);
      rr(5'h14, 32'h0);
      $display("t_large done");
   endtask
   task automatic t_global;
      mem_u.mem[36'h1_0004] = 64'h2_0121;
      mem_u.mem[36'h2_0014] = 64'h6_01A1;
      rw(5'h04, 32'h5, 2'h0);
      rr(5'h04, 32'h5);
      rw(5'h08, 32'h1_0000, 2'h0);
      rr(5'h08, 32'h1_0000);
      xl(32'h0040_3000, N, N, N, Y, 36'h5_0000);
      xl(32'h0040_5678, N, N, N, Y, 36'h6_0678);
      rw(5'h08, 32'h1_0000, 2'h0);
      xl(32'h0040_5000, N, N, N, N, 36'h6_0000);
      xl(32'h0040_3000, N, N, N, Y, 36'h5_0000);
      rw(5'h10, 32'h0, 2'h1);
      xl(32'h0040_3000, N, N, N, N, 36'h5_0000);
      rw(5'h0C, 32'h0040_5000, 2'h0);
      xl(32'h0040_5000, N, N, N, Y, 36'h6_0000);
      rw(5'h04, 32'h1, 2'h0);
      rw(5'h10, 32'h0, 2'h0);
      xl(32'h0040_5000, N, N, N, Y, 36'h6_0000);
      xl(32'h0040_5000, Y, N, N, Y, 36'h6_0000);
      chk("pte", 64'h6_01E1, mem_u.mem[36'h2_0014] & 64'hFFFF_FFFF);
      chk("pde", 64'h2_0121, mem_u.mem[36'h1_0004] & 64'hFFFF_FFFF);
      xl(32'h0040_5000, Y, N, N, N, 36'h6_0000);
      $display("t_global done");
   endtask
   task automatic t_wide;
      mem_u.lat = 3;
      mem_u.mem[36'h3_0028] = 64'h4_0001;
      mem_u.mem[36'h4_0008] = 64'h9_0000_0001;
      mem_u.mem[36'h9_0000_0000] = 64'hA_BCDE_F001;
      mem_u.mem[36'h4_0010] = 64'h7_0020_0081;
      mem_u.mem[36'h4_0018] = 64'h5_0041;
      rw(5'h04, 32'h3, 2'h0);
      rw(5'h08, 32'h3_0020, 2'h0);
      xl(32'h4020_0ABC, N, N, N, Y, 36'hA_BCDE_FABC);
      chk("pte", 64'hA_BCDE_F021, mem_u.mem[36'h9_0000_0000]);
      xl(32'h4040_1234, N, N, N, Y, 36'h7_0020_1234);
      xl(32'h4060_0000, N, N, Y, Y, 36'h0);
      $display("t_wide done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      t_small;
      t_large;
      t_global;
      t_wide;
      final_report;
   end
endmodule // testbench
`default_nettype wire

// File: tb/ptw_walker_chk.sv
// Concurrent checks on the ports of the paging translation unit.
// Assumes one clock and the active-high asynchronous reset of the unit.
`timescale 1ns/100ps
`default_nettype none
module ptw_walker_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic busy_q,
   input wire logic rsp_valid_q,
   input wire logic mem_rd_q,
   input wire logic mem_wr_q,
   input wire logic mem_lock_q,
   input wire logic mem_dword_q,
   input wire logic [35:0] mem_addr_q,
   input wire logic [63:0] mem_wdata_q,
   input wire logic [63:0] mem_rdata,
   input wire logic mem_ack
);
   logic [31:0] last_rd_q;
   logic [35:0] last_ad_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_rd_q <= 32'h0;
         last_ad_q <= 36'h0;
      end else if (mem_ack && mem_rd_q) begin
         last_rd_q <= mem_rdata[31:0];
         last_ad_q <= mem_addr_q;
      end
   end
   //////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_LOCK_WR: assert property (mem_wr_q |-> mem_lock_q)
      else $error("mark write outside locked walk");
   AST_RSP_IDLE: assert property (rsp_valid_q |-> !mem_rd_q && !mem_wr_q && !mem_lock_q)
      else $error("response before memory update done");
   AST_WR_SAME: assert property (mem_wr_q |-> mem_addr_q == last_ad_q)
      else $error("mark write to other entry");
   AST_NO_IDLE_MEM: assert property (!busy_q |-> !mem_rd_q && !mem_wr_q)
      else $error("memory access without walk");
   AST_NARROW: assert property ((mem_rd_q || mem_wr_q) && !mem_dword_q
      |-> mem_addr_q[35:32] == 4'h0 && mem_addr_q[1:0] == 2'h0)
      else $error("narrow entry address bad");
   AST_WIDE: assert property ((mem_rd_q || mem_wr_q) && mem_dword_q
      |-> mem_addr_q[2:0] == 3'h0)
      else $error("wide entry not 8-byte aligned");
   AST_HOLD: assert property (mem_rd_q && !mem_ack |=> mem_rd_q && $stable(mem_addr_q))
      else $error("read dropped before ack");
   AST_KEEP: assert property (mem_wr_q |-> (mem_wdata_q[31:0] & last_rd_q) == last_rd_q)
      else $error("entry bit cleared by update");
   AST_TOUCH: assert property (mem_wr_q |-> mem_wdata_q[5])
      else $error("update without touched mark");
   AST_PTR: assert property ($rose(mem_lock_q) && mem_dword_q
      |-> mem_addr_q[35:32] == 4'h0 && mem_addr_q[2:0] == 3'h0)
      else $error("pointer table address bad");
   AST_DONE: assert property ($rose(busy_q) |-> ##[1:200] rsp_valid_q)
      else $error("walk without response");
endmodule // ptw_walker_chk
bind ptw_walker ptw_walker_chk chk_u (.clk(clk), .rst(rst), .busy_q(busy_q),
   .rsp_valid_q(rsp_valid_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q),
   .mem_lock_q(mem_lock_q), .mem_dword_q(mem_dword_q), .mem_addr_q(mem_addr_q),
   .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
`default_nettype wire
